// File: design/tmr_device.sv
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_device (
    input  wire logic  clock_in,
    input  wire logic  rst_b_in,
    tmr_bus_if.dev     bus,
    input  wire logic  capture_pin_in,
    input  wire logic  comparator_output_in,
    input  wire logic  external_tick_pin_in,
    input  wire logic  prescale_tick_in,
    output logic       count_top_out,
    output logic       count_floor_out
);
    tmr_pkg::tmr_dev_t s;
    tmr_pkg::tmr_dev_t next_s;
    logic              ext_rise;
    logic              ext_fall;
    logic              cap_rise;
    logic              cap_fall;
    logic [3:0]        wgm;

    function automatic logic top_is_cap(input logic [3:0] m);
        return m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he;
    endfunction

    function automatic logic dual_slope(input logic [3:0] m);
        return (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
    endfunction

    function automatic logic fast_mode(input logic [3:0] m);
        return (m >= 4'h5 && m <= 4'h7) || m == 4'he || m == 4'hf;
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m,
                                           input logic [15:0] cap);
        if (top_is_cap(m)) begin
            return cap;
        end
        case (m[1:0])
            2'h1:    return `TMR_TOP_8BIT;
            2'h2:    return `TMR_TOP_9BIT;
            2'h3:    return `TMR_TOP_10BIT;
            default: return `TMR_MAX;
        endcase
    endfunction

    assign wgm = {s.ctrl_b[4:3], s.ctrl_a[1:0]};

    tmr_edge_unit u_tick (
        .clock_in     (clock_in),
        .rst_b_in     (rst_b_in),
        .raw_in       (external_tick_pin_in),
        .filter_en_in (1'b0),
        .enable_in    (1'b1),
        .rise_out     (ext_rise),
        .fall_out     (ext_fall)
    );

    // The source mux sits ahead of the synchroniser, so a source change
    // looks like an edge and may capture; software clears the flag after.
    // source select
    tmr_edge_unit u_capture (
        .clock_in     (clock_in),
        .rst_b_in     (rst_b_in),
        .raw_in       (s.cmp_sel ? comparator_output_in : capture_pin_in),
        .filter_en_in (s.ctrl_b[`TMR_B_NFE]),
        .enable_in    (!top_is_cap(wgm)),
        .rise_out     (cap_rise),
        .fall_out     (cap_fall)
    );

    always_comb begin
        logic        tick;
        logic        cap_ev;
        logic        ovf_ev;
        logic [15:0] top;
        logic [3:0]  nw;
        next_s = s;
        tick   = 1'b0;
        cap_ev = 1'b0;
        ovf_ev = 1'b0;
        nw     = 4'h0;
        top    = top_of(wgm, s.capture);
        case (s.ctrl_b[2:0])
            `TMR_CS_OFF:      tick = 1'b0;
            `TMR_CS_SYS:      tick = 1'b1;
            `TMR_CS_EXT_FALL: tick = ext_fall;
            default: begin
                if (s.ctrl_b[2:0] <= `TMR_CS_PRE_LAST) begin
                    tick = prescale_tick_in;
                end else begin
                    tick = ext_rise;
                end
            end
        endcase
        cap_ev = s.ctrl_b[`TMR_B_EDGE] ? cap_rise : cap_fall;

        if (bus.wr && bus.addr == `TMR_A_CNT_LO) begin
            next_s.count = {s.latch, bus.wdata};
        end else if (tick) begin
            if (dual_slope(wgm)) begin
                if (s.down) begin
                    if (s.count == `TMR_FLOOR) begin
                        next_s.down  = 1'b0;
                        next_s.count = `TMR_ONE;
                    end else begin
                        next_s.count = s.count - `TMR_ONE;
                        if (s.count == `TMR_ONE) begin
                            next_s.down = 1'b0;
                            ovf_ev = 1'b1;
                        end
                    end
                end else if (s.count >= top) begin
                    next_s.down  = 1'b1;
                    next_s.count = s.count - `TMR_ONE;
                end else begin
                    next_s.count = s.count + `TMR_ONE;
                end
            end else begin
                next_s.down = 1'b0;
                if (s.count == top) begin
                    next_s.count = `TMR_FLOOR;
                end else begin
                    next_s.count = s.count + `TMR_ONE;
                end
                ovf_ev = s.count == `TMR_MAX ||
                         (s.count == top && fast_mode(wgm));
            end
        end

        if (cap_ev) begin
            next_s.capture = s.count;
        end else if (bus.wr && bus.addr == `TMR_A_CAP_LO
                     && top_is_cap(wgm)) begin
            next_s.capture = {s.latch, bus.wdata};
        end

        next_s.rdata = `TMR_RST_BYTE;
        if (bus.rd) begin
            case (bus.addr)
                `TMR_A_CTRL_A: next_s.rdata = s.ctrl_a;
                `TMR_A_CTRL_B: next_s.rdata = s.ctrl_b;
                `TMR_A_CNT_LO: begin
                    next_s.rdata = s.count[7:0];
                    next_s.latch = s.count[15:8];
                end
                `TMR_A_CAP_LO: begin
                    next_s.rdata = s.capture[7:0];
                    next_s.latch = s.capture[15:8];
                end
                `TMR_A_CNT_HI, `TMR_A_CAP_HI: next_s.rdata = s.latch;
                `TMR_A_FLAGS: begin
                    next_s.rdata[`TMR_B_CAP] = s.cap_flag;
                    next_s.rdata[`TMR_B_OVF] = s.ovf_flag;
                end
                `TMR_A_MASK: begin
                    next_s.rdata[`TMR_B_CAP] = s.cap_en;
                    next_s.rdata[`TMR_B_OVF] = s.ovf_en;
                end
                `TMR_A_CMP: next_s.rdata[`TMR_B_CMP_SEL] = s.cmp_sel;
                default:    next_s.rdata = `TMR_RST_BYTE;
            endcase
        end

        if (bus.wr) begin
            case (bus.addr)
                `TMR_A_CTRL_A: next_s.ctrl_a = bus.wdata & `TMR_CTRLA_MASK;
                `TMR_A_CTRL_B: next_s.ctrl_b = bus.wdata & `TMR_CTRLB_MASK;
                `TMR_A_CNT_HI, `TMR_A_CAP_HI: next_s.latch = bus.wdata;
                `TMR_A_FLAGS: begin
                    if (bus.wdata[`TMR_B_CAP]) begin
                        next_s.cap_flag = 1'b0;
                    end
                    if (bus.wdata[`TMR_B_OVF]) begin
                        next_s.ovf_flag = 1'b0;
                    end
                end
                `TMR_A_MASK: begin
                    next_s.cap_en = bus.wdata[`TMR_B_CAP];
                    next_s.ovf_en = bus.wdata[`TMR_B_OVF];
                end
                `TMR_A_CMP: next_s.cmp_sel = bus.wdata[`TMR_B_CMP_SEL];
                default: next_s.ctrl_a = s.ctrl_a;
            endcase
        end
        if (bus.ack_cap) begin
            next_s.cap_flag = 1'b0;
        end
        if (bus.ack_ovf) begin
            next_s.ovf_flag = 1'b0;
        end
        // Sets come last so an event in the clearing cycle is kept.
        // flag with the copy
        if (cap_ev) begin
            next_s.cap_flag = 1'b1;
        end
        if (ovf_ev) begin
            next_s.ovf_flag = 1'b1;
        end

        next_s.irq_cap = next_s.cap_flag & next_s.cap_en;
        next_s.irq_ovf = next_s.ovf_flag & next_s.ovf_en;
        nw = {next_s.ctrl_b[4:3], next_s.ctrl_a[1:0]};
        next_s.at_top = next_s.count == top_of(nw, next_s.capture);
        next_s.at_floor = next_s.count == `TMR_FLOOR;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            s          <= '0;
            s.at_floor <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign bus.rdata       = s.rdata;
    assign bus.irq_cap     = s.irq_cap;
    assign bus.irq_ovf     = s.irq_ovf;
    assign count_top_out   = s.at_top;
    assign count_floor_out = s.at_floor;
endmodule

// File: design/tmr_defines.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define TMR_AW          4
`define TMR_A_CTRL_A    4'h0
`define TMR_A_CTRL_B    4'h1
`define TMR_A_CNT_LO    4'h2
`define TMR_A_CNT_HI    4'h3
`define TMR_A_CAP_LO    4'h4
`define TMR_A_CAP_HI    4'h5
`define TMR_A_FLAGS     4'h6
`define TMR_A_MASK      4'h7
`define TMR_A_CMP       4'h8
`define TMR_B_OVF       0
`define TMR_B_CAP       5
`define TMR_B_CMP_SEL   2
`define TMR_B_NFE       7
`define TMR_B_EDGE      6
`define TMR_CTRLB_MASK  8'hdf
`define TMR_CTRLA_MASK  8'h03
`define TMR_RST_BYTE    8'h00
`define TMR_RST_WORD    16'h0000
`define TMR_FILTER_LEN  4
`define TMR_CS_OFF      3'h0
`define TMR_CS_SYS      3'h1
`define TMR_CS_PRE_LAST 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_MAX         16'hffff
`define TMR_FLOOR       16'h0000
`define TMR_ONE         16'h0001
`define TMR_TOP_8BIT    16'h00ff
`define TMR_TOP_9BIT    16'h01ff
`define TMR_TOP_10BIT   16'h03ff
`endif

// File: design/tmr_pkg.sv
// State types for the timer, its edge unit and its CPU end.
`include "tmr_defines.svh"
package tmr_pkg;
    typedef enum logic [3:0] {
        H_IDLE    = 4'b0001,
        H_FIRST   = 4'b0010,
        H_SECOND  = 4'b0100,
        H_COLLECT = 4'b1000
    } tmr_hstate_t;

    typedef struct packed {
        logic [1:0]                   sync;
        logic [`TMR_FILTER_LEN-1:0]   samp;
        logic                         filt;
        logic                         prev;
        logic                         rise;
        logic                         fall;
    } tmr_edge_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture;
        logic [7:0]  latch;
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic        cap_flag;
        logic        ovf_flag;
        logic        cap_en;
        logic        ovf_en;
        logic        cmp_sel;
        logic        down;
        logic [7:0]  rdata;
        logic        irq_cap;
        logic        irq_ovf;
        logic        at_top;
        logic        at_floor;
    } tmr_dev_t;

    typedef struct packed {
        tmr_hstate_t       st;
        logic              wide;
        logic              write;
        logic [3:0]        addr;
        logic [15:0]       data;
        logic [3:0]        bus_addr;
        logic [7:0]        bus_wdata;
        logic              bus_wr;
        logic              bus_rd;
        logic              ack_cap;
        logic              ack_ovf;
        logic              done;
        logic              busy;
        logic              irq_cap;
        logic              irq_ovf;
    } tmr_host_t;
endpackage

// File: design/tmr_bus_if.sv
// Byte-wide register bus between the timer and the CPU end.
`timescale 1ns/1ps
`include "tmr_defines.svh"
interface tmr_bus_if;
    logic [`TMR_AW-1:0] addr;
    logic [7:0]         wdata;
    logic               wr;
    logic               rd;
    logic [7:0]         rdata;
    logic               irq_cap;
    logic               irq_ovf;
    logic               ack_cap;
    logic               ack_ovf;

    modport dev (input addr, wdata, wr, rd, ack_cap, ack_ovf,
                 output rdata, irq_cap, irq_ovf);
    modport host (output addr, wdata, wr, rd, ack_cap, ack_ovf,
                  input rdata, irq_cap, irq_ovf);
endinterface

// File: design/tmr_edge_unit.sv
// Synchroniser, optional four-sample filter and edge detector.
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_edge_unit (
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    input  wire logic raw_in,
    input  wire logic filter_en_in,
    input  wire logic enable_in,
    output logic      rise_out,
    output logic      fall_out
);
    tmr_pkg::tmr_edge_t s;
    tmr_pkg::tmr_edge_t next_s;

    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[0], raw_in};
        next_s.samp = {s.samp[`TMR_FILTER_LEN-2:0], s.sync[1]};
        if (filter_en_in) begin
            if (&s.samp) begin
                next_s.filt = 1'b1;
            end else if (~|s.samp) begin
                next_s.filt = 1'b0;
            end
        end else begin
            next_s.filt = s.sync[1];
        end
        next_s.prev = s.filt;
        next_s.rise = enable_in & s.filt & ~s.prev;
        next_s.fall = enable_in & ~s.filt & s.prev;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise_out = s.rise;
    assign fall_out = s.fall;
endmodule

// File: design/tmr_host.sv
// CPU end: byte and ordered word accesses plus interrupt service.
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_host (
    input  wire logic         clock_in,
    input  wire logic         rst_b_in,
    tmr_bus_if.host           bus,
    input  wire logic         cmd_valid_in,
    input  wire logic         cmd_write_in,
    input  wire logic         cmd_wide_in,
    input  wire logic [3:0]   cmd_addr_in,
    input  wire logic [15:0]  cmd_data_in,
    input  wire logic         cap_service_in,
    input  wire logic         ovf_service_in,
    output logic              busy_out,
    output logic              done_out,
    output logic [15:0]       result_out,
    output logic              cap_irq_out,
    output logic              ovf_irq_out
);
    tmr_pkg::tmr_host_t s;
    tmr_pkg::tmr_host_t next_s;

    always_comb begin
        next_s         = s;
        next_s.bus_wr  = 1'b0;
        next_s.bus_rd  = 1'b0;
        next_s.done    = 1'b0;
        next_s.ack_cap = cap_service_in;
        next_s.ack_ovf = ovf_service_in;
        next_s.irq_cap = bus.irq_cap;
        next_s.irq_ovf = bus.irq_ovf;
        case (s.st)
            tmr_pkg::H_IDLE: begin
                if (cmd_valid_in) begin
                    next_s.st        = tmr_pkg::H_FIRST;
                    next_s.wide      = cmd_wide_in;
                    next_s.write     = cmd_write_in;
                    next_s.addr      = cmd_addr_in;
                    next_s.data      = cmd_data_in;
                    next_s.bus_wr    = cmd_write_in;
                    next_s.bus_rd    = !cmd_write_in;
                    next_s.bus_addr  = cmd_addr_in;
                    next_s.bus_wdata = cmd_data_in[7:0];
                    // high write first, low read first
                    if (cmd_wide_in && cmd_write_in) begin
                        next_s.bus_addr  = cmd_addr_in + 4'h1;
                        next_s.bus_wdata = cmd_data_in[15:8];
                    end
                end
            end
            tmr_pkg::H_FIRST: begin
                if (s.wide) begin
                    next_s.st       = tmr_pkg::H_SECOND;
                    next_s.bus_wr   = s.write;
                    next_s.bus_rd   = !s.write;
                    next_s.bus_addr = s.write ? s.addr : s.addr + 4'h1;
                    next_s.bus_wdata = s.data[7:0];
                end else if (s.write) begin
                    next_s.st   = tmr_pkg::H_IDLE;
                    next_s.done = 1'b1;
                end else begin
                    next_s.st = tmr_pkg::H_COLLECT;
                end
            end
            tmr_pkg::H_SECOND: begin
                if (s.write) begin
                    next_s.st   = tmr_pkg::H_IDLE;
                    next_s.done = 1'b1;
                end else begin
                    next_s.st        = tmr_pkg::H_COLLECT;
                    next_s.data[7:0] = bus.rdata;
                end
            end
            tmr_pkg::H_COLLECT: begin
                next_s.st   = tmr_pkg::H_IDLE;
                next_s.done = 1'b1;
                if (s.wide) begin
                    next_s.data[15:8] = bus.rdata;
                end else begin
                    next_s.data = {8'h00, bus.rdata};
                end
            end
            default: next_s.st = tmr_pkg::H_IDLE;
        endcase
        next_s.busy = next_s.st != tmr_pkg::H_IDLE;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            s    <= '0;
            s.st <= tmr_pkg::H_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign bus.addr    = s.bus_addr;
    assign bus.wdata   = s.bus_wdata;
    assign bus.wr      = s.bus_wr;
    assign bus.rd      = s.bus_rd;
    assign bus.ack_cap = s.ack_cap;
    assign bus.ack_ovf = s.ack_ovf;
    assign busy_out    = s.busy;
    assign done_out    = s.done;
    assign result_out  = s.data;
    assign cap_irq_out = s.irq_cap;
    assign ovf_irq_out = s.irq_ovf;
endmodule

// File: verification/tmr_bus_props.sv
// Concurrent checks on the byte bus between the timer and its CPU end.
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_bus_props (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata,
    input  wire logic       irq_cap,
    input  wire logic       irq_ovf,
    input  wire logic       ack_cap,
    input  wire logic       ack_ovf
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    logic [7:0] shadow_latch;
    logic [7:0] shadow_ctrlb;
    logic [7:0] shadow_mask;
    logic       shadow_ok;

    // A low-byte read fills the shared byte from a word this checker
    // cannot see, so the shadow is only trusted until such a read.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            shadow_latch <= 8'h00;
            shadow_ctrlb <= 8'h00;
            shadow_mask  <= 8'h00;
            shadow_ok    <= 1'b1;
        end else begin
            if (wr && (addr == `TMR_A_CNT_HI || addr == `TMR_A_CAP_HI)) begin
                shadow_latch <= wdata;
                shadow_ok    <= 1'b1;
            end else if (rd && (addr == `TMR_A_CNT_LO ||
                                addr == `TMR_A_CAP_LO)) begin
                shadow_ok <= 1'b0;
            end
            if (wr && addr == `TMR_A_CTRL_B) begin
                shadow_ctrlb <= wdata;
            end
            if (wr && addr == `TMR_A_MASK) begin
                shadow_mask <= wdata;
            end
        end
    end

    sequence pair_rd_s;
        rd ##1 rd;
    endsequence
    sequence pair_wr_s;
        wr ##1 wr;
    endsequence

    chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero after an idle cycle");
    chk_unmapped_read: assert property (rd && addr > `TMR_A_CMP |=> rdata == 8'h00)
        else $error("unmapped read returned nonzero data");
    chk_shared_latch: assert property (rd && shadow_ok && (addr == `TMR_A_CNT_HI || addr == `TMR_A_CAP_HI) |=> rdata == shadow_latch)
        else $error("high byte read does not return the shared byte");
    chk_ctrlb_readback: assert property (rd && !wr && addr == `TMR_A_CTRL_B |=> rdata == (shadow_ctrlb & `TMR_CTRLB_MASK))
        else $error("control B readback mismatch");
    chk_cap_irq_mask: assert property ((!shadow_mask[`TMR_B_CAP])[*2] |-> !irq_cap)
        else $error("capture request while masked");
    chk_ovf_irq_mask: assert property ((!shadow_mask[`TMR_B_OVF])[*2] |-> !irq_ovf)
        else $error("overflow request while masked");
    chk_read_order: assert property (pair_rd_s |-> addr == $past(addr) + 4'h1 && ($past(addr) == `TMR_A_CNT_LO || $past(addr) == `TMR_A_CAP_LO))
        else $error("word read not low byte then high byte");
    chk_write_order: assert property (pair_wr_s |-> addr == $past(addr) - 4'h1)
        else $error("word write not high byte then low byte");
    chk_ack_pulse: assert property (ack_cap |=> !ack_cap)
        else $error("service acknowledge longer than one cycle");
endmodule

// File: verification/timer16_counter_capture_bench.sv
// Self-checking bench joining the timer and its CPU end over the byte bus.
`timescale 1ns/1ps
`include "tmr_defines.svh"
module timer16_counter_capture_bench;
    logic        clock_in  = 1'b0;
    logic        rst_b_in  = 1'b0;
    logic        cap_pin   = 1'b0;
    logic        cmp_out   = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    logic        cmd_wide  = 1'b0;
    logic [3:0]  cmd_addr  = 4'h0;
    logic [15:0] cmd_data  = 16'h0000;
    logic        cap_srv   = 1'b0;
    logic        ext_pin   = 1'b0;
    logic        busy;
    logic        ovf_irq;
    logic        top_flag;
    logic        done;
    logic        cap_irq;
    logic        floor_flag;
    logic [15:0] result;
    logic [15:0] first;
    int          bad_count = 0;
    int          checked   = 0;

    tmr_bus_if tmr_bus_if_i ();
    tmr_device tmr_device_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .bus(tmr_bus_if_i), .capture_pin_in(cap_pin),
        .comparator_output_in(cmp_out), .external_tick_pin_in(ext_pin),
        .prescale_tick_in(1'b0), .count_top_out(top_flag),
        .count_floor_out(floor_flag));
    tmr_host tmr_host_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .bus(tmr_bus_if_i), .cmd_valid_in(cmd_valid),
        .cmd_write_in(cmd_write), .cmd_wide_in(cmd_wide),
        .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
        .cap_service_in(cap_srv), .ovf_service_in(1'b0), .busy_out(busy),
        .done_out(done), .result_out(result), .cap_irq_out(cap_irq),
        .ovf_irq_out(ovf_irq));
    tmr_bus_props tmr_bus_props_i (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .addr(tmr_bus_if_i.addr),
        .wdata(tmr_bus_if_i.wdata), .wr(tmr_bus_if_i.wr),
        .rd(tmr_bus_if_i.rd), .rdata(tmr_bus_if_i.rdata),
        .irq_cap(tmr_bus_if_i.irq_cap), .irq_ovf(tmr_bus_if_i.irq_ovf),
        .ack_cap(tmr_bus_if_i.ack_cap), .ack_ovf(tmr_bus_if_i.ack_ovf));

    always #10 clock_in = ~clock_in;

    task automatic end_sim();
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic expect16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic w, input logic wd, input logic [3:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge clock_in);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_wide  = wd;
        cmd_addr  = a;
        cmd_data  = d;
        @(posedge clock_in);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 10) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        if (n == 10 || busy !== 1'b0) begin
            bad_count++;
            $display("[FAIL] %0t command never completed", $time);
        end
    endtask

    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        cmd(1'b1, 1'b0, a, {8'h00, d});
    endtask

    task automatic rd(input logic wd, input logic [3:0] a,
                      input logic [15:0] exp);
        cmd(1'b0, wd, a, 16'h0000);
        expect16(result, exp);
    endtask

    // Holds the new levels long enough for a filtered capture to land.
    task automatic drive(input logic p, input logic c);
        @(posedge clock_in);
        #1;
        cap_pin = p;
        cmp_out = c;
        repeat (12) @(posedge clock_in);
        #1;
    endtask

    initial begin
        #100000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clock_in);
        #1;
        rst_b_in = 1'b1;
        expect16({15'h0000, floor_flag}, 16'h0001);
        rd(1'b1, `TMR_A_CNT_LO, 16'h0000);
        wr8(`TMR_A_CTRL_B, 8'hff);
        rd(1'b0, `TMR_A_CTRL_B, 16'h00df);
        wr8(`TMR_A_CTRL_B, 8'h00);
        rd(1'b0, 4'h9, 16'h0000);
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'h1234);
        rd(1'b1, `TMR_A_CNT_LO, 16'h1234);
        expect16({15'h0000, floor_flag}, 16'h0000);
        wr8(`TMR_A_CNT_HI, 8'h5a);
        rd(1'b0, `TMR_A_CAP_HI, 16'h005a);
        wr8(`TMR_A_CNT_LO, 8'h11);
        rd(1'b1, `TMR_A_CNT_LO, 16'h5a11);
        cmd(1'b1, 1'b1, `TMR_A_CAP_LO, 16'h7777);
        rd(1'b1, `TMR_A_CAP_LO, 16'h0000);
        wr8(`TMR_A_CTRL_B, 8'h18);
        cmd(1'b1, 1'b1, `TMR_A_CAP_LO, 16'h0042);
        rd(1'b1, `TMR_A_CAP_LO, 16'h0042);
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'h0042);
        expect16({15'h0000, top_flag}, 16'h0001);
        wr8(`TMR_A_CTRL_B, 8'h58);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
        rd(1'b1, `TMR_A_CAP_LO, 16'h0042);
        // Two word reads issued back to back are five cycles apart.
        wr8(`TMR_A_CTRL_B, 8'h01);
        cmd(1'b0, 1'b1, `TMR_A_CNT_LO, 16'h0000);
        first = result;
        rd(1'b1, `TMR_A_CNT_LO, first + 16'd5);
        // The low write lands on a tick; three ticks follow before the stop.
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'h2000);
        wr8(`TMR_A_CTRL_B, 8'h00);
        cmd(1'b0, 1'b1, `TMR_A_CNT_LO, 16'h0000);
        first = result;
        expect16(first, 16'h2003);
        rd(1'b1, `TMR_A_CNT_LO, first);
        wr8(`TMR_A_CTRL_B, 8'h07);
        repeat (3) begin
            @(posedge clock_in);
            #1;
            ext_pin = 1'b1;
            repeat (4) @(posedge clock_in);
            #1;
            ext_pin = 1'b0;
            repeat (4) @(posedge clock_in);
        end
        wr8(`TMR_A_CTRL_B, 8'h00);
        rd(1'b1, `TMR_A_CNT_LO, 16'h2006);
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'hfffc);
        wr8(`TMR_A_CTRL_B, 8'h01);
        repeat (10) @(posedge clock_in);
        wr8(`TMR_A_CTRL_B, 8'h00);
        wr8(`TMR_A_MASK, 8'h01);
        rd(1'b0, `TMR_A_FLAGS, 16'h0001);
        expect16({15'h0000, ovf_irq}, 16'h0001);
        wr8(`TMR_A_FLAGS, 8'h01);
        rd(1'b0, `TMR_A_FLAGS, 16'h0000);
        expect16({15'h0000, ovf_irq}, 16'h0000);
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'h3c3c);
        wr8(`TMR_A_MASK, 8'h20);
        wr8(`TMR_A_CTRL_B, 8'h40);
        drive(1'b1, 1'b0);
        expect16({15'h0000, cap_irq}, 16'h0001);
        rd(1'b1, `TMR_A_CAP_LO, 16'h3c3c);
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'h4d4d);
        drive(1'b0, 1'b0);
        rd(1'b1, `TMR_A_CAP_LO, 16'h3c3c);
        wr8(`TMR_A_CTRL_B, 8'h00);
        wr8(`TMR_A_FLAGS, 8'h20);
        rd(1'b0, `TMR_A_FLAGS, 16'h0000);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
        rd(1'b1, `TMR_A_CAP_LO, 16'h4d4d);
        expect16({15'h0000, cap_irq}, 16'h0001);
        @(posedge clock_in);
        #1;
        cap_srv = 1'b1;
        @(posedge clock_in);
        #1;
        cap_srv = 1'b0;
        repeat (6) @(posedge clock_in);
        #1;
        expect16({15'h0000, cap_irq}, 16'h0000);
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'h6e6e);
        wr8(`TMR_A_CMP, 8'h04);
        wr8(`TMR_A_FLAGS, 8'h20);
        wr8(`TMR_A_CTRL_B, 8'h40);
        drive(1'b1, 1'b0);
        rd(1'b1, `TMR_A_CAP_LO, 16'h4d4d);
        drive(1'b1, 1'b1);
        rd(1'b1, `TMR_A_CAP_LO, 16'h6e6e);
        wr8(`TMR_A_FLAGS, 8'h20);
        rd(1'b0, `TMR_A_FLAGS, 16'h0000);
        drive(1'b0, 1'b0);
        wr8(`TMR_A_CMP, 8'h00);
        cmd(1'b1, 1'b1, `TMR_A_CNT_LO, 16'h0f0f);
        wr8(`TMR_A_CTRL_B, 8'hc0);
        // A three-cycle spike must not pass the four-sample filter.
        @(posedge clock_in);
        #1;
        cap_pin = 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        cap_pin = 1'b0;
        drive(1'b0, 1'b0);
        rd(1'b1, `TMR_A_CAP_LO, 16'h6e6e);
        drive(1'b1, 1'b0);
        rd(1'b1, `TMR_A_CAP_LO, 16'h0f0f);
        end_sim();
    end
endmodule
